// ---- design/ufc_fifo_ctrl.sv ----
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module ufc_fifo_ctrl (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire ufc_pkg::ufc_bus_type bus,
   output logic [7:0] rd_data,
   input wire ufc_pkg::ufc_byte_type rx_in,
   output logic rx_in_ready,
   output ufc_pkg::ufc_byte_type tx_out,
   input wire logic tx_out_ready,
   input wire logic rx_timeout,
   output logic tx_dma_request_n,
   output logic rx_dma_request_n,
   output logic rx_data_irq,
   output logic [7:0] status_bits
);
   import ufc_pkg::*;

   function automatic logic [`UFC_CNT_W-1:0] trig_level(input logic [1:0] sel,
                                                      input logic deep);
      logic [`UFC_CNT_W-1:0] lv;
      lv = `UFC_T16_0;
      case (sel)
         2'h0: lv = deep ? `UFC_T64_0 : `UFC_T16_0;
         2'h1: lv = deep ? `UFC_T64_1 : `UFC_T16_1;
         2'h2: lv = deep ? `UFC_T64_2 : `UFC_T16_2;
         default: lv = deep ? `UFC_T64_3 : `UFC_T16_3;
      endcase
      return lv;
   endfunction : trig_level

   // ****************************************
   // fifo control register
   // ****************************************
   logic [7:0] fc_q, fc_d;
   logic tx_clr, rx_clr, fifo_en, dma1, deep;
   logic [1:0] trig_sel;
   always_comb begin
      fc_d = fc_q;
      if (bus.wr && bus.addr == `UFC_FIFO_CONTROL_ADDR) begin
         fc_d = bus.wdata;
         fc_d[4] = 1'b0;
      end
      // clear bits never stay set
      fc_d[`UFC_BIT_TX_CLEAR] = 1'b0;
      fc_d[`UFC_BIT_RX_CLEAR] = 1'b0;
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fc_q <= `UFC_FC_RESET;
      end else begin
         fc_q <= fc_d;
      end
   end
   assign tx_clr = bus.wr && bus.addr == `UFC_FIFO_CONTROL_ADDR
                   && bus.wdata[`UFC_BIT_TX_CLEAR];
   assign rx_clr = bus.wr && bus.addr == `UFC_FIFO_CONTROL_ADDR
                   && bus.wdata[`UFC_BIT_RX_CLEAR];
   assign fifo_en = fc_q[`UFC_BIT_ENABLE];
   assign dma1 = fc_q[`UFC_BIT_DMA_MODE];
   assign deep = fc_q[`UFC_BIT_DEPTH64];
   assign trig_sel = fc_q[`UFC_TRIG_HI:`UFC_TRIG_LO];

   // disabled fifos act as a single holding register
   logic [`UFC_CNT_W-1:0] cap;
   assign cap = !fifo_en ? 7'h01 : (deep ? `UFC_FULL64 : `UFC_FULL16);

   // ****************************************
   // transmit fifo
   // ****************************************
   logic [`UFC_PTR_W-1:0] twp_q, twp_d, trp_q, trp_d;
   logic [`UFC_CNT_W-1:0] tcnt_q, tcnt_d;
   logic tpend_q, tpend_d;
   logic tx_push, tx_pop, tsk_ready;
   logic [7:0] tmem_rd;
   ufc_byte_type tsk_in;
   assign tx_push = bus.wr && bus.addr == `UFC_TX_DATA_ADDR && tcnt_q < cap;
   assign tx_pop = tcnt_q != 7'h00 && !tpend_q && tsk_ready;
   always_comb begin
      twp_d = twp_q + {5'h00, tx_push};
      trp_d = trp_q + {5'h00, tx_pop};
      tcnt_d = tcnt_q + {6'h00, tx_push} - {6'h00, tx_pop};
      tpend_d = tx_pop;
      if (tx_clr) begin
         twp_d = 6'h00;
         trp_d = 6'h00;
         tcnt_d = 7'h00;
         tpend_d = 1'b0;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         twp_q <= 6'h00;
         trp_q <= 6'h00;
         tcnt_q <= 7'h00;
         tpend_q <= 1'b0;
      end else begin
         twp_q <= twp_d;
         trp_q <= trp_d;
         tcnt_q <= tcnt_d;
         tpend_q <= tpend_d;
      end
   end
   ufc_mem u_tx_mem (
      .core_clk(core_clk),
      .wr_en(tx_push),
      .wr_addr(twp_q),
      .wr_data(bus.wdata),
      .rd_addr(trp_q),
      .rd_data(tmem_rd)
   );
   assign tsk_in.valid = tpend_q;
   assign tsk_in.data = tmem_rd;
   // shifter side keeps its word on clear; only queue is flushed
   ufc_skid u_tx_skid (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .flush(1'b0),
      .in_word(tsk_in),
      .in_ready(tsk_ready),
      .out_word(tx_out),
      .out_ready(tx_out_ready)
   );

   // ****************************************
   // receive fifo
   // ****************************************
   logic [`UFC_PTR_W-1:0] rwp_q, rwp_d, rrp_q, rrp_d;
   logic [`UFC_CNT_W-1:0] rcnt_q, rcnt_d;
   logic rx_push, rx_pop;
   logic [7:0] rmem_rd;
   assign rx_in_ready = rcnt_q < cap && !rx_clr;
   assign rx_push = rx_in.valid && rx_in_ready;
   assign rx_pop = bus.rd && bus.addr == `UFC_RX_DATA_ADDR && rcnt_q != 7'h00;
   always_comb begin
      rwp_d = rwp_q + {5'h00, rx_push};
      rrp_d = rrp_q + {5'h00, rx_pop};
      rcnt_d = rcnt_q + {6'h00, rx_push} - {6'h00, rx_pop};
      if (rx_clr) begin
         rwp_d = 6'h00;
         rrp_d = 6'h00;
         rcnt_d = 7'h00;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rwp_q <= 6'h00;
         rrp_q <= 6'h00;
         rcnt_q <= 7'h00;
      end else begin
         rwp_q <= rwp_d;
         rrp_q <= rrp_d;
         rcnt_q <= rcnt_d;
      end
   end
   ufc_mem u_rx_mem (
      .core_clk(core_clk),
      .wr_en(rx_push),
      .wr_addr(rwp_q),
      .wr_data(rx_in.data),
      .rd_addr(rrp_q),
      .rd_data(rmem_rd)
   );

   // ****************************************
   // dma ready and interrupt level
   // ****************************************
   logic at_trig;
   logic txr_q, txr_d, rxr_q, rxr_d, irq_q, irq_d;
   logic tx_full;
   assign at_trig = rcnt_q >= trig_level(trig_sel, deep);
   assign tx_full = tcnt_q == cap;
   always_comb begin
      txr_d = txr_q;
      rxr_d = rxr_q;
      if (fifo_en && dma1) begin
         if (tx_full) begin
            txr_d = 1'b1;
         end else if (tcnt_q == 7'h00) begin
            txr_d = 1'b0;
         end
         if (at_trig || (rx_timeout && rcnt_q != 7'h00)) begin
            rxr_d = 1'b0;
         end else if (rcnt_q == 7'h00) begin
            rxr_d = 1'b1;
         end
      end else begin
         txr_d = tcnt_q != 7'h00;
         rxr_d = rcnt_q == 7'h00;
      end
      // data ready level follows trigger when enabled, any data when disabled; drops below it
      irq_d = fifo_en ? at_trig : rcnt_q != 7'h00;
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         txr_q <= 1'b0;
         rxr_q <= 1'b1;
         irq_q <= 1'b0;
      end else begin
         txr_q <= txr_d;
         rxr_q <= rxr_d;
         irq_q <= irq_d;
      end
   end
   // dma obeys these levels, so no overrun guard beyond cap
   assign tx_dma_request_n = txr_q;
   assign rx_dma_request_n = rxr_q;
   assign rx_data_irq = irq_q;

   // ****************************************
   // read port
   // ****************************************
   logic [7:0] sts;
   logic [7:0] rdd_d;
   logic [1:0] rsel_q;
   logic rvld_q;
   assign sts = {fifo_en, fifo_en, deep, 5'h00};
   assign status_bits = {irq_q, irq_q, deep, 5'h00} & {fifo_en, fifo_en, 6'h3F};
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsel_q <= 2'h0;
         rvld_q <= 1'b0;
      end else begin
         rsel_q <= bus.addr;
         rvld_q <= bus.rd;
      end
   end
   logic [7:0] sts_q;
   logic [7:0] fcr_q2;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sts_q <= 8'h00;
         fcr_q2 <= 8'h00;
      end else begin
         sts_q <= sts;
         fcr_q2 <= fc_q;
      end
   end
   always_comb begin
      rdd_d = 8'h00;
      if (rvld_q) begin
         case (rsel_q)
            `UFC_FIFO_CONTROL_ADDR: rdd_d = fcr_q2;
            `UFC_STATUS_ADDR: rdd_d = sts_q;
            `UFC_RX_DATA_ADDR: rdd_d = rmem_rd;
            default: rdd_d = 8'h00;
         endcase
      end
   end
   assign rd_data = rdd_d;

   // ****************************************
   // checks
   // ****************************************
   a_tx_clear_empties: assert property (@(posedge core_clk) disable iff (!reset_n)
      tx_clr |=> tcnt_q == 7'h00) else $error("tx clear left data");
   a_rx_clear_empties: assert property (@(posedge core_clk) disable iff (!reset_n)
      rx_clr |=> rcnt_q == 7'h00) else $error("rx clear left data");
   a_clear_bits_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      fc_q[2:1] == 2'h0) else $error("clear bit stuck");
   a_rx_full_cap: assert property (@(posedge core_clk) disable iff (!reset_n)
      rcnt_q <= cap || $past(fc_q) != fc_q) else $error("rx over cap");
   a_m0_rx_ready: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!dma1 && rcnt_q != 7'h00 && !rx_clr) |=> !rx_dma_request_n || !fifo_en
      || $changed(fc_q)) else $error("mode0 rx ready");
   a_m0_tx_ready: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!dma1 && $stable(fc_q)) |=> tx_dma_request_n == ($past(tcnt_q) != 7'h00))
      else $error("mode0 tx ready");
   a_m1_tx_full: assert property (@(posedge core_clk) disable iff (!reset_n)
      (fifo_en && dma1 && tx_full) |=> tx_dma_request_n) else $error("mode1 tx");
   a_m1_rx_trig: assert property (@(posedge core_clk) disable iff (!reset_n)
      (fifo_en && dma1 && at_trig) |=> !rx_dma_request_n) else $error("mode1 rx");
   a_irq_level: assert property (@(posedge core_clk) disable iff (!reset_n)
      (fifo_en && !at_trig) ##1 $stable(fc_q) |-> !rx_data_irq)
      else $error("irq above level");
endmodule : ufc_fifo_ctrl

// ---- design/ufc_cfg.svh ----
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
// ****************************************
// register map
// ****************************************
`define UFC_ADDR_W 2
`define UFC_FIFO_CONTROL_ADDR 2'h0
`define UFC_STATUS_ADDR 2'h1
`define UFC_TX_DATA_ADDR 2'h2
`define UFC_RX_DATA_ADDR 2'h3
`define UFC_FC_RESET 8'h00
`define UFC_BIT_ENABLE 0
`define UFC_BIT_RX_CLEAR 1
`define UFC_BIT_TX_CLEAR 2
`define UFC_BIT_DMA_MODE 3
`define UFC_BIT_DEPTH64 5
`define UFC_TRIG_HI 7
`define UFC_TRIG_LO 6
// ****************************************
// fifo sizes and trigger levels
// ****************************************
`define UFC_MEM_DEPTH 64
`define UFC_PTR_W 6
`define UFC_CNT_W 7
`define UFC_FULL16 7'h10
`define UFC_FULL64 7'h40
`define UFC_T16_0 7'h01
`define UFC_T16_1 7'h04
`define UFC_T16_2 7'h08
`define UFC_T16_3 7'h0E
`define UFC_T64_0 7'h01
`define UFC_T64_1 7'h10
`define UFC_T64_2 7'h20
`define UFC_T64_3 7'h38
`endif

// ---- design/ufc_pkg.sv ----
package ufc_pkg;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ufc_byte_type;
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ufc_bus_type;
endpackage : ufc_pkg

// ---- design/ufc_mem.sv ----
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module ufc_mem (
   input wire logic core_clk,
   input wire logic wr_en,
   input wire logic [`UFC_PTR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [`UFC_PTR_W-1:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:`UFC_MEM_DEPTH-1];
   // no reset on storage; read data registered
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : ufc_mem

// ---- design/ufc_skid.sv ----
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module ufc_skid
   import ufc_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic flush,
   input wire ufc_pkg::ufc_byte_type in_word,
   output logic in_ready,
   output ufc_pkg::ufc_byte_type out_word,
   input wire logic out_ready
);
   // two-entry buffer: a stalled receiver never drops a word
   logic [7:0] e0_q, e0_d, e1_q, e1_d;
   logic [1:0] n_q, n_d;
   logic push, pop;
   assign in_ready = (n_q != 2'h2);
   assign push = in_word.valid && in_ready;
   assign pop = (n_q != 2'h0) && out_ready;
   always_comb begin
      e0_d = e0_q;
      e1_d = e1_q;
      n_d = n_q;
      if (pop) begin
         e0_d = e1_q;
      end
      if (push) begin
         if ((n_q == 2'h0) || (n_q == 2'h1 && pop)) begin
            e0_d = in_word.data;
         end else begin
            e1_d = in_word.data;
         end
      end
      n_d = n_q + {1'b0, push} - {1'b0, pop};
      if (flush) begin
         n_d = 2'h0;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         e0_q <= 8'h00;
         e1_q <= 8'h00;
         n_q <= 2'h0;
      end else begin
         e0_q <= e0_d;
         e1_q <= e1_d;
         n_q <= n_d;
      end
   end
   assign out_word.valid = (n_q != 2'h0);
   assign out_word.data = e0_q;
endmodule : ufc_skid

// ---- tb/ufc_shifter_model.sv ----
`timescale 1ns/1ps
module ufc_shifter_model
   import ufc_pkg::*;
(
   input wire logic core_clk,
   output ufc_pkg::ufc_byte_type rx_in,
   input wire logic rx_in_ready,
   input wire ufc_pkg::ufc_byte_type tx_out,
   output logic tx_out_ready,
   input wire logic stall
);
   int n_tx = 0;
   logic [7:0] last_tx = 8'h00;
   initial rx_in = '{valid: 1'b0, data: 8'h00};
   assign tx_out_ready = !stall;
   always @(posedge core_clk) begin
      if (tx_out.valid === 1'b1 && tx_out_ready) begin
         last_tx <= tx_out.data;
         n_tx <= n_tx + 1;
      end
   end
   // holds the word until ready is seen, gives up after four edges
   task automatic send(input logic [7:0] b, output logic ok);
      @(posedge core_clk);
      rx_in <= '{valid: 1'b1, data: b};
      ok = 1'b0;
      for (int n = 0; n < 4 && !ok; n++) begin
         @(posedge core_clk);
         ok = (rx_in_ready === 1'b1);
      end
      // released line shows the inverse, not a stale copy
      rx_in <= '{valid: 1'b0, data: ~b};
   endtask : send
endmodule : ufc_shifter_model

// ---- tb/uart_fifo_control_dma_ready_test.sv ----
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module uart_fifo_control_dma_ready_test;
   import ufc_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   ufc_bus_type bus = '0;
   ufc_byte_type rx_in, tx_out;
   logic [7:0] rd_data, status_bits, v, cap, head, n_ok;
   logic [7:0] nb = 8'h00;
   logic rx_in_ready, tx_out_ready, tx_dma_request_n, rx_dma_request_n, rx_data_irq, ok;
   logic rx_timeout = 1'b0;
   logic stall = 1'b1;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n0;
   logic [7:0] lvl [8] = '{8'h01, 8'h04, 8'h08, 8'h0E, 8'h01, 8'h10, 8'h20, 8'h38};
   ufc_fifo_ctrl i_ufc_fifo_ctrl (.core_clk, .reset_n, .bus, .rd_data, .rx_in, .rx_in_ready,
      .tx_out, .tx_out_ready, .rx_timeout, .tx_dma_request_n, .rx_dma_request_n,
      .rx_data_irq, .status_bits);
   ufc_shifter_model i_ufc_shifter_model (.core_clk, .rx_in, .rx_in_ready, .tx_out,
      .tx_out_ready, .stall);
   initial forever #2 core_clk = ~core_clk;
   // ****************************************
   // access and compare tasks
   // ****************************************
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1 d = rd_data;
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : idle
   task automatic push(input logic [7:0] n, output logic [7:0] acc);
      acc = 8'h00;
      repeat (n) begin
         i_ufc_shifter_model.send(nb, ok);
         if (ok) begin
            acc++;
            nb++;
         end
      end
   endtask : push
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chk_bit
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // ****************************************
   // tests
   // ****************************************
   initial begin
      #100000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      idle(1);
      chk_bit(tx_dma_request_n, 1'b0);
      chk_bit(rx_dma_request_n, 1'b1);
      rd(`UFC_FIFO_CONTROL_ADDR, v);
      chk(v, 8'h00);
      rd(`UFC_STATUS_ADDR, v);
      chk(v, 8'h00);
      chk(status_bits, 8'h00);
      // single holding register: fourth word finds no room while stalled
      for (int i = 0; i < 4; i++) begin
         wr(`UFC_TX_DATA_ADDR, 8'h50 + 8'(i));
         idle(4);
      end
      chk_bit(tx_dma_request_n, 1'b1);
      stall <= 1'b0;
      idle(12);
      chk(8'(i_ufc_shifter_model.n_tx), 8'h03);
      chk(i_ufc_shifter_model.last_tx, 8'h52);
      chk_bit(tx_dma_request_n, 1'b0);
      push(8'h02, n_ok);
      chk(n_ok, 8'h01);
      idle(3);
      chk_bit(rx_dma_request_n, 1'b0);
      rd(`UFC_RX_DATA_ADDR, v);
      idle(3);
      chk_bit(rx_dma_request_n, 1'b1);
      for (int k = 0; k < 8; k++) begin
         cap = k[2] ? 8'h40 : 8'h10;
         wr(`UFC_FIFO_CONTROL_ADDR, {k[1:0], k[2], 5'h03});
         rd(`UFC_STATUS_ADDR, v);
         chk(v, {2'h3, k[2], 5'h00});
         rd(`UFC_FIFO_CONTROL_ADDR, v);
         chk(v, {k[1:0], k[2], 5'h01});
         head = nb;
         push(lvl[k] - 8'h01, n_ok);
         idle(3);
         chk_bit(rx_data_irq, 1'b0);
         push(8'h01, n_ok);
         idle(3);
         chk_bit(rx_data_irq, 1'b1);
         chk(status_bits, {2'h3, k[2], 5'h00});
         chk_bit(rx_dma_request_n, 1'b0);
         rd(`UFC_RX_DATA_ADDR, v);
         chk(v, head);
         idle(3);
         chk_bit(rx_data_irq, 1'b0);
         chk(status_bits, {2'h0, k[2], 5'h00});
         push(cap - lvl[k] + 8'h02, n_ok);
         chk(n_ok, cap - lvl[k] + 8'h01);
      end
      wr(`UFC_FIFO_CONTROL_ADDR, 8'hCB);
      push(8'h0D, n_ok);
      idle(3);
      chk_bit(rx_dma_request_n, 1'b1);
      push(8'h01, n_ok);
      idle(3);
      chk_bit(rx_dma_request_n, 1'b0);
      repeat (13) rd(`UFC_RX_DATA_ADDR, v);
      chk_bit(rx_dma_request_n, 1'b0);
      rd(`UFC_RX_DATA_ADDR, v);
      idle(3);
      chk_bit(rx_dma_request_n, 1'b1);
      push(8'h01, n_ok);
      rx_timeout <= 1'b1;
      idle(3);
      rx_timeout <= 1'b0;
      chk_bit(rx_dma_request_n, 1'b0);
      wr(`UFC_FIFO_CONTROL_ADDR, 8'hCB);
      idle(3);
      chk_bit(rx_dma_request_n, 1'b1);
      // mode 1 transmit with the shifter stalled: 16 queued plus 2 buffered
      stall <= 1'b1;
      wr(`UFC_FIFO_CONTROL_ADDR, 8'h0D);
      idle(3);
      n0 = i_ufc_shifter_model.n_tx;
      for (int i = 0; i < 18; i++) begin
         chk_bit(tx_dma_request_n, 1'b0);
         wr(`UFC_TX_DATA_ADDR, 8'h80 + 8'(i));
         idle(2);
      end
      chk_bit(tx_dma_request_n, 1'b1);
      wr(`UFC_FIFO_CONTROL_ADDR, 8'h0D);
      idle(3);
      chk_bit(tx_dma_request_n, 1'b0);
      stall <= 1'b0;
      idle(12);
      chk(8'(i_ufc_shifter_model.n_tx - n0), 8'h02);
      chk(i_ufc_shifter_model.last_tx, 8'h81);
      print_verdict();
   end
endmodule : uart_fifo_control_dma_ready_test
